// *** axwc_regs.vh ***
// Purpose: constants for the slot width and clock-rate adapter
// Assumes: included by bare name from the design files
// Notes:   burst encodings follow the published bus protocol
//
// Summary of operation
// - wider wrap length is ceil(bytes/wide)-1
// - wrap if new length nonzero, else incr
// - write wrap address rounds offset up
// - read wrap address truncates offset down
// - narrow fixed burst splits into incr transfers
// - changed length sets size to output width
// - integer clock reduction toward downstream side
// - integer clock acceleration toward downstream side
// - asynchronous mode carries write data through fifo
// - sample cycle is phase zero of a counter cleared by reset, all channels
// - each slot timed by its own clock
// - two-deep skid buffer per channel per slot
// - each skid stage adds one cycle latency
// - skid stages run on the slot clock
`ifndef AXWC_REGS_VH
`define AXWC_REGS_VH

`define AXWC_BURST_FIXED 2'h0
`define AXWC_BURST_INCR  2'h1
`define AXWC_BURST_WRAP  2'h2

`define AXWC_RATE_SYNC   2'h0
`define AXWC_RATE_REDUCE 2'h1
`define AXWC_RATE_ACCEL  2'h2
`define AXWC_RATE_ASYNC  2'h3

`define AXWC_CACHE_MOD_BIT 1
`define AXWC_PAYLOAD_W     50
`define AXWC_WDATA_W       32
`define AXWC_FIFO_DEPTH    4
`define AXWC_FIFO_AW       2

`endif

// *** axwc_fifo.v ***
// Purpose: small write-data fifo with gray pointers
// Assumes: one clock; in_ready and out_valid are built from flops only
// Notes:   pointer copies pass two flops before they are compared
`include "axwc_regs.vh"
`default_nettype none

module axwc_fifo #(
  parameter W  = 33,
  parameter D  = 4,
  parameter AW = 2
) (
  input  wire         i_clk,
  input  wire         i_rst_b,
  input  wire         i_in_valid,
  output wire         o_in_ready,
  input  wire [W-1:0] i_in_data,
  output wire         o_out_valid,
  input  wire         i_out_ready,
  output wire [W-1:0] o_out_data
);
  reg  [W-1:0]  mem_reg [0:D-1];
  reg  [AW:0]   wr_bin_reg;
  reg  [AW:0]   rd_bin_reg;
  reg  [AW:0]   wr_gray_reg;
  reg  [AW:0]   rd_gray_reg;
  reg  [AW:0]   wr_gray_s1_reg;
  reg  [AW:0]   wr_gray_s2_reg;
  reg  [AW:0]   rd_gray_s1_reg;
  reg  [AW:0]   rd_gray_s2_reg;
  wire [AW:0]   wr_bin_next;
  wire [AW:0]   rd_bin_next;
  wire          full;
  wire          empty;
  wire          push;
  wire          pop;

  // full and empty compare the local pointer with the other side's second-stage copy
  assign full        = (wr_gray_reg == {~rd_gray_s2_reg[AW:AW-1], rd_gray_s2_reg[AW-2:0]});
  assign empty       = (rd_gray_reg == wr_gray_s2_reg);
  assign o_in_ready  = ~full;
  assign o_out_valid = ~empty;
  assign o_out_data  = mem_reg[rd_bin_reg[AW-1:0]];
  assign push        = i_in_valid & ~full;
  assign pop         = i_out_ready & ~empty;
  assign wr_bin_next = wr_bin_reg + {{AW{1'b0}}, push};
  assign rd_bin_next = rd_bin_reg + {{AW{1'b0}}, pop};

  // storage write
  always @(posedge i_clk) begin
    if (push) begin
      mem_reg[wr_bin_reg[AW-1:0]] <= i_in_data;
    end
  end

  // pointers and their synchronised gray copies
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wr_bin_reg     <= {(AW+1){1'b0}};
      rd_bin_reg     <= {(AW+1){1'b0}};
      wr_gray_reg    <= {(AW+1){1'b0}};
      rd_gray_reg    <= {(AW+1){1'b0}};
      wr_gray_s1_reg <= {(AW+1){1'b0}};
      wr_gray_s2_reg <= {(AW+1){1'b0}};
      rd_gray_s1_reg <= {(AW+1){1'b0}};
      rd_gray_s2_reg <= {(AW+1){1'b0}};
    end else begin
      wr_bin_reg     <= wr_bin_next;
      rd_bin_reg     <= rd_bin_next;
      wr_gray_reg    <= wr_bin_next ^ (wr_bin_next >> 1);
      rd_gray_reg    <= rd_bin_next ^ (rd_bin_next >> 1);
      wr_gray_s1_reg <= wr_gray_reg;
      wr_gray_s2_reg <= wr_gray_s1_reg;
      rd_gray_s1_reg <= rd_gray_reg;
      rd_gray_s2_reg <= rd_gray_s1_reg;
    end
  end
endmodule

`default_nettype wire

// *** axwc_slot.v ***
// Purpose: one slot of the adapter: skid buffers, burst width conversion
//          of wrap and fixed bursts, integer clock-rate gating, data fifo
// Assumes: single clock i_clk; configuration inputs steady while busy
// Notes:   all outputs are flops; incr width conversion is not done here
//          clock-rate gating by phase stands in for separate slot clocks
`include "axwc_regs.vh"
`default_nettype none

module axwc_slot (
  input  wire        i_clk,
  input  wire        i_rst_b,
  // configuration, held steady while requests are in flight
  input  wire [2:0]  i_in_lg,
  input  wire [2:0]  i_out_lg,
  input  wire [1:0]  i_rate_mode,
  input  wire [3:0]  i_rate_div,
  // upstream address channel
  input  wire        i_s_avalid,
  output wire        o_s_aready,
  input  wire [31:0] i_s_aaddr,
  input  wire [7:0]  i_s_alen,
  input  wire [2:0]  i_s_asize,
  input  wire [1:0]  i_s_aburst,
  input  wire [3:0]  i_s_acache,
  input  wire        i_s_awrite,
  // downstream address channel
  output wire        o_m_avalid,
  input  wire        i_m_aready,
  output wire [31:0] o_m_aaddr,
  output wire [7:0]  o_m_alen,
  output wire [2:0]  o_m_asize,
  output wire [1:0]  o_m_aburst,
  output wire        o_m_awrite,
  // upstream write data channel
  input  wire        i_s_wvalid,
  output wire        o_s_wready,
  input  wire [31:0] i_s_wdata,
  input  wire        i_s_wlast,
  // downstream write data channel
  output wire        o_m_wvalid,
  input  wire        i_m_wready,
  output wire [31:0] o_m_wdata,
  output wire        o_m_wlast
);
  localparam PW = `AXWC_PAYLOAD_W;

  // skid buffer wiring, channel 0 address, channel 1 write data
  wire [2*PW-1:0] sk_in_data;
  wire [1:0]      sk_in_valid;
  wire [1:0]      sk_in_ready;
  wire [2*PW-1:0] sk_out_data;
  wire [1:0]      sk_out_valid;
  wire [1:0]      sk_dn_ready;

  assign sk_in_valid = {i_s_wvalid, i_s_avalid};
  assign sk_in_data  = {{(PW-33){1'b0}}, i_s_wlast, i_s_wdata,
                        i_s_awrite, i_s_acache, i_s_aburst, i_s_asize, i_s_alen, i_s_aaddr};
  assign o_s_aready  = sk_in_ready[0];
  assign o_s_wready  = sk_in_ready[1];

  // two-deep skid stage per channel at the slot edge, slot clock
  // ready is a flop of its own so the upstream pin sees no gate
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_skid
      reg          main_v_reg;
      reg          skid_v_reg;
      reg          skid_free_reg;
      reg [PW-1:0] main_d_reg;
      reg [PW-1:0] skid_d_reg;
      wire         take;
      wire         acc;
      assign take = main_v_reg & sk_dn_ready[g];
      assign acc  = sk_in_valid[g] & skid_free_reg;
      assign sk_in_ready[g]            = skid_free_reg;
      assign sk_out_valid[g]           = main_v_reg;
      assign sk_out_data[g*PW +: PW]   = main_d_reg;
      always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
          main_v_reg    <= 1'b0;
          skid_v_reg    <= 1'b0;
          skid_free_reg <= 1'b1;
          main_d_reg    <= {PW{1'b0}};
          skid_d_reg    <= {PW{1'b0}};
        end else if (~main_v_reg | take) begin
          if (skid_v_reg) begin
            main_d_reg    <= skid_d_reg;
            main_v_reg    <= 1'b1;
            skid_v_reg    <= 1'b0;
            skid_free_reg <= 1'b1;
          end else begin
            main_d_reg <= sk_in_data[g*PW +: PW];
            main_v_reg <= acc;
          end
        end else if (acc) begin
          skid_d_reg    <= sk_in_data[g*PW +: PW];
          skid_v_reg    <= 1'b1;
          skid_free_reg <= 1'b0;
        end
      end
    end
  endgenerate

  // rate phase: the sampling cycle of the slower side is the phase zero
  // a ratio of 0 or 1 holds the phase at zero, so no cycle is gated
  reg  [3:0] phase_reg;
  wire [3:0] phase_last;
  wire       in_ok;
  wire       out_ok;
  assign phase_last = (i_rate_div == 4'h0) ? 4'h0 : i_rate_div - 4'h1;
  assign out_ok = (i_rate_mode != `AXWC_RATE_REDUCE) | (phase_reg == 4'h0);
  assign in_ok  = (i_rate_mode != `AXWC_RATE_ACCEL) | (phase_reg == 4'h0);

  // free-running phase counter on the slot clock
  // phase zero is the one cycle on which the slower side has an edge
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      phase_reg <= 4'h0;
    end else if (phase_reg >= phase_last) begin
      phase_reg <= 4'h0;
    end else begin
      phase_reg <= phase_reg + 4'h1;
    end
  end

  // unpack the held address request
  wire [31:0] c_addr;
  wire [7:0]  c_len;
  wire [2:0]  c_size;
  wire [1:0]  c_burst;
  wire [3:0]  c_cache;
  wire        c_write;
  assign {c_write, c_cache, c_burst, c_size, c_len, c_addr} = sk_out_data[PW-1:0];

  // wrap span, offset and boundary
  // span is (len+1) beats of 2^size bytes; the boundary aligns to it
  // write rounds the start up to a wide word and wraps past the span
  wire [15:0] burst_bytes;
  wire [15:0] burst_mask;
  wire [15:0] wrap_off;
  wire [31:0] wrap_addr;
  wire [15:0] ob;
  wire [15:0] obm;
  wire [15:0] up_len16;
  wire [15:0] wr_off;
  wire [15:0] rd_off;
  assign burst_bytes = ({8'h0, c_len} + 16'h1) << c_size;
  assign burst_mask  = burst_bytes - 16'h1;
  assign wrap_off    = c_addr[15:0] & burst_mask;
  assign wrap_addr   = c_addr & ~{16'h0, burst_mask};
  assign ob          = 16'h1 << i_out_lg;
  assign obm         = ob - 16'h1;
  assign up_len16    = ((burst_bytes + obm) >> i_out_lg) - 16'h1;
  assign wr_off      = ((wrap_off + obm) & ~obm) & burst_mask;
  assign rd_off      = wrap_off & ~obm;

  // fixed split toward narrower side
  // every piece starts at the original address, one piece per beat
  // align_beats counts narrow beats skipped inside the first wide word
  wire [7:0] ratio;
  wire [7:0] in_mask;
  wire [7:0] align_beats;
  wire [7:0] fix_len;
  assign ratio       = 8'h1 << (i_in_lg - i_out_lg);
  assign in_mask     = (8'h1 << i_in_lg) - 8'h1;
  assign align_beats = (c_addr[7:0] & in_mask) >> i_out_lg;
  assign fix_len     = (ratio > align_beats + 8'h1) ? ratio - align_beats - 8'h1 : 8'h0;

  // which conversion applies to the held request
  // only wrap widening and fixed narrowing change a request
  wire is_wrap_up;
  wire is_fix_dn;
  assign is_wrap_up = (c_burst == `AXWC_BURST_WRAP) & (i_out_lg > i_in_lg)
                      & c_cache[`AXWC_CACHE_MOD_BIT];
  assign is_fix_dn  = (c_burst == `AXWC_BURST_FIXED) & (i_out_lg < i_in_lg)
                      & (c_size > i_out_lg);

  // converted request
  reg [31:0] cv_addr;
  reg [7:0]  cv_len;
  reg [2:0]  cv_size;
  reg [1:0]  cv_burst;
  always @* begin
    cv_addr  = c_addr;
    cv_len   = c_len;
    cv_size  = c_size;
    cv_burst = c_burst;
    if (is_wrap_up) begin
      cv_len   = up_len16[7:0];
      cv_size  = i_out_lg;
      cv_burst = (up_len16[7:0] != 8'h0) ? `AXWC_BURST_WRAP : `AXWC_BURST_INCR;
      if (c_write) begin
        cv_addr = wrap_addr + {16'h0, wr_off};
      end else begin
        cv_addr = wrap_addr + {16'h0, rd_off};
      end
    end else if (is_fix_dn) begin
      cv_len   = fix_len;
      cv_size  = i_out_lg;
      cv_burst = `AXWC_BURST_INCR;
    end
  end

  // address output register and split counter
  reg        m_avalid_reg;
  reg [31:0] m_aaddr_reg;
  reg [7:0]  m_alen_reg;
  reg [2:0]  m_asize_reg;
  reg [1:0]  m_aburst_reg;
  reg        m_awrite_reg;
  reg [7:0]  split_cnt_reg;
  wire       a_free;
  wire       a_load;
  wire       a_last_piece;
  assign a_free       = ~m_avalid_reg | (i_m_aready & out_ok);
  assign a_load       = a_free & sk_out_valid[0] & in_ok;
  assign a_last_piece = ~is_fix_dn | (split_cnt_reg == c_len);
  assign sk_dn_ready[0] = a_load & a_last_piece;

  // issue each piece; a split request stays in the skid until its last piece
  // the piece count lives in split_cnt_reg, so the held fields never move
  // and a stalled piece is simply offered again
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      m_avalid_reg  <= 1'b0;
      m_aaddr_reg   <= 32'h0;
      m_alen_reg    <= 8'h0;
      m_asize_reg   <= 3'h0;
      m_aburst_reg  <= 2'h0;
      m_awrite_reg  <= 1'b0;
      split_cnt_reg <= 8'h0;
    end else if (a_load) begin
      m_avalid_reg  <= 1'b1;
      m_aaddr_reg   <= cv_addr;
      m_alen_reg    <= cv_len;
      m_asize_reg   <= cv_size;
      m_aburst_reg  <= cv_burst;
      m_awrite_reg  <= c_write;
      split_cnt_reg <= a_last_piece ? 8'h0 : split_cnt_reg + 8'h1;
    end else if (a_free) begin
      m_avalid_reg  <= 1'b0;
    end
  end

  // every downstream address pin comes straight from its register
  assign o_m_avalid = m_avalid_reg;
  assign o_m_aaddr  = m_aaddr_reg;
  assign o_m_alen   = m_alen_reg;
  assign o_m_asize  = m_asize_reg;
  assign o_m_aburst = m_aburst_reg;
  assign o_m_awrite = m_awrite_reg;

  // write data: skid then fifo then output register
  // pointer sync in the fifo costs latency but keeps empty and full safe
  // when the slot and core clocks really differ
  wire        f_out_valid;
  wire [32:0] f_out_data;
  wire        w_free;
  wire        w_load;

  axwc_fifo #(
    .W  (33),
    .D  (`AXWC_FIFO_DEPTH),
    .AW (`AXWC_FIFO_AW)
  ) u_wfifo (
    .i_clk       (i_clk),
    .i_rst_b     (i_rst_b),
    .i_in_valid  (sk_out_valid[1]),
    .o_in_ready  (sk_dn_ready[1]),
    .i_in_data   (sk_out_data[PW +: 33]),
    .o_out_valid (f_out_valid),
    .i_out_ready (w_load),
    .o_out_data  (f_out_data)
  );

  reg        m_wvalid_reg;
  reg [31:0] m_wdata_reg;
  reg        m_wlast_reg;
  assign w_free = ~m_wvalid_reg | (i_m_wready & out_ok);
  assign w_load = w_free & f_out_valid & in_ok;

  // data output register, drained only on the downstream sampling cycle
  // outside accel mode refilled in the cycle it is taken, so a burst of up to four words flows without bubbles
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      m_wvalid_reg <= 1'b0;
      m_wdata_reg  <= 32'h0;
      m_wlast_reg  <= 1'b0;
    end else if (w_load) begin
      m_wvalid_reg <= 1'b1;
      m_wdata_reg  <= f_out_data[31:0];
      m_wlast_reg  <= f_out_data[32];
    end else if (w_free) begin
      m_wvalid_reg <= 1'b0;
    end
  end

  // write pins straight from their registers
  assign o_m_wvalid = m_wvalid_reg;
  assign o_m_wdata  = m_wdata_reg;
  assign o_m_wlast  = m_wlast_reg;
endmodule

`default_nettype wire

// *** axwc_slot_assertions.sv ***
// Purpose: port checks for axwc_slot
// Assumes: sync mode: address out two cycles after take, data after five
// Notes:   bound to every axwc_slot instance
`include "axwc_regs.vh"
`default_nettype none
module axwc_chk (
  input wire logic        i_clk,
  input wire logic        i_rst_b,
  input wire logic [2:0]  i_in_lg,
  input wire logic [2:0]  i_out_lg,
  input wire logic [1:0]  i_rate_mode,
  input wire logic        i_s_avalid,
  input wire logic        o_s_aready,
  input wire logic        o_m_avalid,
  input wire logic        i_m_aready,
  input wire logic [31:0] o_m_aaddr,
  input wire logic [7:0]  o_m_alen,
  input wire logic [2:0]  o_m_asize,
  input wire logic [1:0]  o_m_aburst,
  input wire logic        i_s_wvalid,
  input wire logic        o_s_wready,
  input wire logic        o_m_wvalid,
  input wire logic        i_m_wready,
  input wire logic [31:0] o_m_wdata,
  input wire logic        o_m_wlast
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] aq_reg;
  logic [3:0] wq_reg;
  logic       sync;
  default clocking slot_cyc @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  assign sync = (i_rate_mode == `AXWC_RATE_SYNC);
  // cycles since the last take per channel, saturating, so idle is known
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      aq_reg <= 4'hf;
      wq_reg <= 4'hf;
    end else begin
      aq_reg <= (i_s_avalid && o_s_aready) ? 4'h0 : aq_reg + {3'h0, aq_reg != 4'hf};
      wq_reg <= (i_s_wvalid && o_s_wready) ? 4'h0 : wq_reg + {3'h0, wq_reg != 4'hf};
    end
  end
  chk_reset_ready: assert property ($rose(i_rst_b) |-> o_s_aready && o_s_wready)
    else $error("skid not empty after reset");
  chk_reset_valid: assert property ($rose(i_rst_b) |-> !o_m_avalid && !o_m_wvalid)
    else $error("output valid after reset");
  chk_addr_hold: assert property (o_m_avalid && !i_m_aready |=> o_m_avalid
    && $stable(o_m_aaddr) && $stable(o_m_alen) && $stable(o_m_aburst))
    else $error("address request changed before it was taken");
  chk_wdata_hold: assert property (o_m_wvalid && !i_m_wready |=> o_m_wvalid
    && $stable(o_m_wdata) && $stable(o_m_wlast))
    else $error("write word changed before it was taken");
  chk_wrap_len: assert property (o_m_avalid && i_out_lg > i_in_lg
    && o_m_aburst == `AXWC_BURST_WRAP |-> o_m_alen != 8'h0)
    else $error("wrap burst of one beat");
  chk_fixed_size: assert property (o_m_avalid && i_in_lg > i_out_lg
    && o_m_aburst == `AXWC_BURST_FIXED |-> o_m_asize <= i_out_lg)
    else $error("wide fixed burst not split");
  chk_addr_latency: assert property (sync && i_s_avalid && o_s_aready
    && !o_m_avalid && aq_reg == 4'hf |=> !o_m_avalid ##1 o_m_avalid)
    else $error("address latency not two cycles");
  chk_wdata_path: assert property (sync && i_s_wvalid && o_s_wready
    && !o_m_wvalid && wq_reg == 4'hf |=> !o_m_wvalid [*3] ##[1:4] o_m_wvalid)
    else $error("write word not carried through fifo");
  cov_addr_take: cover property (i_s_avalid && o_s_aready);
  cov_addr_stall: cover property (!o_s_aready);
  cov_wdata_stall: cover property (!o_s_wready);
  cov_split: cover property (o_m_avalid && i_in_lg > i_out_lg && o_m_aburst == 2'h1);
endmodule
bind axwc_slot axwc_chk i_chk (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_in_lg(i_in_lg),
  .i_out_lg(i_out_lg), .i_rate_mode(i_rate_mode), .i_s_avalid(i_s_avalid),
  .o_s_aready(o_s_aready), .o_m_avalid(o_m_avalid), .i_m_aready(i_m_aready),
  .o_m_aaddr(o_m_aaddr), .o_m_alen(o_m_alen), .o_m_asize(o_m_asize),
  .o_m_aburst(o_m_aburst), .i_s_wvalid(i_s_wvalid), .o_s_wready(o_s_wready),
  .o_m_wvalid(o_m_wvalid), .i_m_wready(i_m_wready), .o_m_wdata(o_m_wdata),
  .o_m_wlast(o_m_wlast));
`default_nettype wire

// *** axwc_sink.sv ***
// Purpose: downstream slave model for axwc_slot
// Assumes: same clock as the slot; reduce-mode slow edges kept by a count
// Notes:   logs every accepted request and word in order
`include "axwc_regs.vh"
`default_nettype none
module axwc_sink (
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_stall,
  input  wire logic        i_slow,
  input  wire logic [1:0]  i_mode,
  input  wire logic [3:0]  i_div,
  input  wire logic        i_avalid,
  input  wire logic [31:0] i_aaddr,
  input  wire logic [7:0]  i_alen,
  input  wire logic [2:0]  i_asize,
  input  wire logic [1:0]  i_aburst,
  input  wire logic        i_awrite,
  output logic             o_aready,
  input  wire logic        i_wvalid,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wlast,
  output logic             o_wready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [45:0] aq[$];
  logic [32:0] wq[$];
  logic        ph_reg;
  logic [3:0]  edge_reg;
  logic        take_ok;
  // in reduce mode the slower side only has an edge where the count is zero
  assign take_ok = (i_mode != `AXWC_RATE_REDUCE) || (edge_reg == 4'h0);
  // ready after each edge; slow mode accepts every other cycle
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ph_reg <= 1'b0;
      edge_reg <= 4'h0;
      o_aready <= 1'b0;
      o_wready <= 1'b0;
    end else begin
      if (i_avalid && o_aready && take_ok)
        aq.push_back({i_aaddr, i_alen, i_asize, i_aburst, i_awrite});
      if (i_wvalid && o_wready && take_ok) wq.push_back({i_wlast, i_wdata});
      edge_reg <= (edge_reg + 4'h1 >= i_div) ? 4'h0 : edge_reg + 4'h1;
      ph_reg <= !ph_reg;
      o_aready <= !i_stall && (!i_slow || ph_reg);
      o_wready <= !i_stall && (!i_slow || !ph_reg);
    end
  end
endmodule
`default_nettype wire

// *** axi_slot_width_clock_adapter_test.sv ***
// Purpose: self-checking bench for axwc_slot
// Assumes: one clock for slot, core and model
// Notes:   expectations worked out by hand from the conversion rules
`include "axwc_regs.vh"
`default_nettype none
module axi_slot_width_clock_adapter_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst_b = 1'b0, stall = 1'b0, slow = 1'b0;
  logic [2:0] in_lg = 3'h2, out_lg = 3'h2, asize = 3'h0;
  logic [1:0] mode = 2'h0, aburst = 2'h0;
  logic [3:0] div = 4'h0, acache = 4'h0;
  logic avalid = 1'b0, awrite = 1'b0, wvalid = 1'b0, wlast = 1'b0;
  logic [31:0] aaddr = 32'h0, wdata = 32'h0, m_aaddr, m_wdata;
  logic [7:0] alen = 8'h0, m_alen;
  logic [2:0] m_asize;
  logic [1:0] m_aburst;
  logic s_aready, m_avalid, m_aready, m_awrite, s_wready, m_wvalid, m_wready, m_wlast;
  int n_mismatch = 0, check_count = 0;
  // slot and core share this clock, the fastest in the system
  always #20 clk = ~clk;
  axwc_slot i_dut (.i_clk(clk), .i_rst_b(rst_b), .i_in_lg(in_lg), .i_out_lg(out_lg),
    .i_rate_mode(mode), .i_rate_div(div), .i_s_avalid(avalid), .o_s_aready(s_aready),
    .i_s_aaddr(aaddr), .i_s_alen(alen), .i_s_asize(asize), .i_s_aburst(aburst),
    .i_s_acache(acache), .i_s_awrite(awrite), .o_m_avalid(m_avalid), .i_m_aready(m_aready),
    .o_m_aaddr(m_aaddr), .o_m_alen(m_alen), .o_m_asize(m_asize), .o_m_aburst(m_aburst),
    .o_m_awrite(m_awrite), .i_s_wvalid(wvalid), .o_s_wready(s_wready), .i_s_wdata(wdata),
    .i_s_wlast(wlast), .o_m_wvalid(m_wvalid), .i_m_wready(m_wready), .o_m_wdata(m_wdata),
    .o_m_wlast(m_wlast));
  axwc_sink i_sink (.i_clk(clk), .i_rst_b(rst_b), .i_stall(stall), .i_slow(slow),
    .i_mode(mode), .i_div(div),
    .i_avalid(m_avalid), .i_aaddr(m_aaddr), .i_alen(m_alen), .i_asize(m_asize),
    .i_aburst(m_aburst), .i_awrite(m_awrite), .o_aready(m_aready), .i_wvalid(m_wvalid),
    .i_wdata(m_wdata), .i_wlast(m_wlast), .o_wready(m_wready));
  task automatic chk(input string name, input logic [63:0] e, input logic [63:0] g);
    check_count++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", name, e, g);
      n_mismatch++;
    end
  endtask
  task automatic cfg(input logic [2:0] il, input logic [2:0] ol, input logic [1:0] m);
    in_lg <= il;
    out_lg <= ol;
    mode <= m;
    div <= 4'h3;
    @(posedge clk);
  endtask
  // request held until the edge that takes it; valid stays up for the next one
  task automatic send_a(input logic [31:0] ad, input logic [7:0] ln, input logic [2:0] sz,
                        input logic [1:0] bu, input logic [3:0] ca, input logic wr);
    logic r;
    avalid <= 1'b1;
    {aaddr, alen, asize, aburst, acache, awrite} <= {ad, ln, sz, bu, ca, wr};
    do begin
      @(negedge clk);
      r = s_aready;
      @(posedge clk);
    end while (r !== 1'b1);
  endtask
  task automatic send_w(input logic [31:0] d, input logic l);
    logic r;
    wvalid <= 1'b1;
    {wdata, wlast} <= {d, l};
    do begin
      @(negedge clk);
      r = s_wready;
      @(posedge clk);
    end while (r !== 1'b1);
  endtask
  task automatic quiet();
    avalid <= 1'b0;
    wvalid <= 1'b0;
    @(posedge clk);
  endtask
  task automatic exp_a(input logic [31:0] ad, input logic [7:0] ln, input logic [2:0] sz,
                       input logic [1:0] bu, input logic wr);
    for (int k = 0; k < 200 && i_sink.aq.size() == 0; k++) @(posedge clk);
    chk("m_a", {ad, ln, sz, bu, wr}, i_sink.aq.size() ? i_sink.aq.pop_front() : 64'hx);
  endtask
  task automatic exp_w(input logic [31:0] d, input logic l);
    for (int k = 0; k < 200 && i_sink.wq.size() == 0; k++) @(posedge clk);
    chk("m_w", {l, d}, i_sink.wq.size() ? i_sink.wq.pop_front() : 64'hx);
  endtask
  task automatic t_rates();
    for (int m = 0; m < 4; m++) begin
      cfg(3'h2, 3'h2, m[1:0]);
      send_a(32'h1000 + m, 8'h03, 3'h2, `AXWC_BURST_INCR, 4'h0, 1'b1);
      quiet();
      exp_a(32'h1000 + m, 8'h03, 3'h2, `AXWC_BURST_INCR, 1'b1);
    end
  endtask
  task automatic t_wrap();
    cfg(3'h2, 3'h3, `AXWC_RATE_SYNC);
    send_a(32'h104, 8'h03, 3'h2, `AXWC_BURST_WRAP, 4'h2, 1'b1);
    send_a(32'h104, 8'h03, 3'h2, `AXWC_BURST_WRAP, 4'h2, 1'b0);
    send_a(32'h104, 8'h01, 3'h2, `AXWC_BURST_WRAP, 4'h2, 1'b1);
    send_a(32'h10c, 8'h01, 3'h2, `AXWC_BURST_WRAP, 4'h2, 1'b0);
    send_a(32'h104, 8'h03, 3'h2, `AXWC_BURST_WRAP, 4'h0, 1'b1);
    quiet();
    exp_a(32'h108, 8'h01, 3'h3, `AXWC_BURST_WRAP, 1'b1);
    exp_a(32'h100, 8'h01, 3'h3, `AXWC_BURST_WRAP, 1'b0);
    exp_a(32'h100, 8'h00, 3'h3, `AXWC_BURST_INCR, 1'b1);
    exp_a(32'h108, 8'h00, 3'h3, `AXWC_BURST_INCR, 1'b0);
    exp_a(32'h104, 8'h03, 3'h2, `AXWC_BURST_WRAP, 1'b1);
  endtask
  task automatic t_fixed();
    slow <= 1'b1;
    cfg(3'h3, 3'h2, `AXWC_RATE_SYNC);
    send_a(32'h204, 8'h01, 3'h3, `AXWC_BURST_FIXED, 4'h0, 1'b1);
    send_a(32'h200, 8'h00, 3'h3, `AXWC_BURST_FIXED, 4'h0, 1'b0);
    send_a(32'h208, 8'h02, 3'h2, `AXWC_BURST_FIXED, 4'h0, 1'b1);
    quiet();
    repeat (2) exp_a(32'h204, 8'h00, 3'h2, `AXWC_BURST_INCR, 1'b1);
    exp_a(32'h200, 8'h01, 3'h2, `AXWC_BURST_INCR, 1'b0);
    exp_a(32'h208, 8'h02, 3'h2, `AXWC_BURST_FIXED, 1'b1);
    slow <= 1'b0;
  endtask
  // far side stalls for 30 cycles, both channels must then refuse, then it drains slowly
  task automatic t_stall();
    cfg(3'h2, 3'h2, `AXWC_RATE_SYNC);
    stall <= 1'b1;
    fork
      for (int i = 0; i < 6; i++) send_a(32'h300 + 4 * i, 8'h0, 3'h2, 2'h1, 4'h0, 1'b1);
      for (int i = 0; i < 10; i++) send_w(32'ha0 + i, i == 9);
      begin
        repeat (30) @(posedge clk);
        chk("s_aready", 1'b0, s_aready);
        chk("s_wready", 1'b0, s_wready);
        stall <= 1'b0;
        slow <= 1'b1;
      end
    join
    quiet();
    for (int i = 0; i < 6; i++) exp_a(32'h300 + 4 * i, 8'h0, 3'h2, 2'h1, 1'b1);
    for (int i = 0; i < 10; i++) exp_w(32'ha0 + i, i == 9);
    slow <= 1'b0;
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_rates();
    t_wrap();
    t_fixed();
    t_stall();
    end_of_test();
  end
  initial begin
    #400000;
    n_mismatch++;
    end_of_test();
  end
endmodule
`default_nettype wire
